/* otpc_ctl.sv */
// apb-controlled host that reads, programs and identifies a 16k x 8 otp rom
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "otpc_consts.svh"

// Contract
// - host keeps every unselected rom with an enable high
// - program mode: 13 V and 6.5 V supplies, output enable high, chip low
// - byte presented on data pins; strobe only after address and data stable
// - each attempt is a 100 us strobe then read-back verify
// - at most 10 attempts per byte, then report failure
// - parallel roms share address, data and strobe lines
// - final verify of all bytes with both supplies at 5 V; code has no such pass, a read checks one byte
// - first strobe lasts 95 to 105 us, nominal 100 us
// - in signature mode all other address lines held low
module otpc_ctl #(
	parameter int PULSE_CYC = `OTPC_PULSE_CYC,
	parameter int SETUP_CYC = `OTPC_SETUP_CYC,
	parameter int MAX_TRIES = `OTPC_MAX_TRIES
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic      [13:0] addr_lines_o,
	output logic             chip_on_low_o,
	output logic             out_drv_on_n_o,
	output logic             burn_pulse_n_o,
	output logic             burn_supply_hi_o,
	output logic             vcc_prog_o,
	output logic             id_volt_hi_o,
	input  wire logic [7:0]  byte_pins_i,
	output logic      [7:0]  byte_pins_o,
	output logic             byte_pins_oe_o
);
	localparam logic [15:0] PULSE_LD = 16'(PULSE_CYC - 1);
	localparam logic [15:0] SETUP_LD = 16'(SETUP_CYC - 1);
	localparam logic [15:0] ACC_LD   = 16'(`OTPC_ACC_CYC + `OTPC_SYNC_CYC - 1);
	localparam logic [15:0] DIS_LD   = 16'(`OTPC_DIS_CYC - 1);
	localparam logic [3:0]  TRY_MAX  = 4'(MAX_TRIES);

	// ------------------------------------------------------------------------
	// apb register slave
	// ------------------------------------------------------------------------
	logic                 pready_q, pready_d;
	logic                 pslverr_q, pslverr_d;
	logic [31:0]          prdata_q, prdata_d;
	logic [13:0]          addr_reg_q, addr_reg_d;
	logic [7:0]           wdata_reg_q, wdata_reg_d;
	otpc_pkg::otpc_cmd_t  cmd_reg_q, cmd_reg_d;
	logic                 start;
	logic                 wr_en;
	logic                 mapped;

	otpc_pkg::otpc_state_t st_q, st_d;
	otpc_pkg::otpc_pins_t  pins_q, pins_d;
	logic [7:0]            dat_q, dat_d;
	logic                  oe_q, oe_d;
	logic [3:0]            tries_q, tries_d;
	logic                  done_q, done_d;
	logic                  fail_q, fail_d;
	logic [7:0]            rdata_q, rdata_d;
	logic                  tm_load;
	logic [15:0]           tm_val;
	logic                  tm_zero;
	logic [7:0]            byte_sync;

	assign wr_en  = ce_i && psel_i && penable_i && pready_q && pwrite_i;
	assign mapped = (paddr_i == `OTPC_REG_CTRL) || (paddr_i == `OTPC_REG_ADDR) ||
	                (paddr_i == `OTPC_REG_WDATA) || (paddr_i == `OTPC_REG_STATUS);
	// orders arriving while a sequence runs are dropped; status shows busy
	assign start  = wr_en && (paddr_i == `OTPC_REG_CTRL) && pwdata_i[`OTPC_CTRL_START] &&
	                (st_q == otpc_pkg::OTPC_ST_IDLE);

	always_comb begin
		pready_d    = pready_q;
		pslverr_d   = pslverr_q;
		prdata_d    = prdata_q;
		addr_reg_d  = addr_reg_q;
		wdata_reg_d = wdata_reg_q;
		cmd_reg_d   = cmd_reg_q;
		if (ce_i) begin
			pready_d  = 1'b0;
			pslverr_d = 1'b0;
			if (psel_i && !penable_i) begin
				pready_d  = 1'b1;
				pslverr_d = !mapped;
				prdata_d  = 32'h0000_0000;
				case (paddr_i)
					`OTPC_REG_CTRL: begin
						prdata_d[`OTPC_CTRL_CMD_HI:`OTPC_CTRL_CMD_LO] = cmd_reg_q;
					end
					`OTPC_REG_ADDR: begin
						prdata_d[13:0] = addr_reg_q;
					end
					`OTPC_REG_WDATA: begin
						prdata_d[7:0] = wdata_reg_q;
					end
					`OTPC_REG_STATUS: begin
						prdata_d[`OTPC_ST_BUSY] = (st_q != otpc_pkg::OTPC_ST_IDLE);
						prdata_d[`OTPC_ST_DONE] = done_q;
						prdata_d[`OTPC_ST_FAIL] = fail_q;
						prdata_d[`OTPC_ST_TRY_HI:`OTPC_ST_TRY_LO] = tries_q;
						prdata_d[`OTPC_ST_RD_HI:`OTPC_ST_RD_LO]   = rdata_q;
					end
					default: begin
						prdata_d = 32'h0000_0000;
					end
				endcase
			end
			if (wr_en && (st_q == otpc_pkg::OTPC_ST_IDLE)) begin
				case (paddr_i)
					`OTPC_REG_CTRL: begin
						cmd_reg_d = otpc_pkg::otpc_cmd_t'(
							pwdata_i[`OTPC_CTRL_CMD_HI:`OTPC_CTRL_CMD_LO]);
					end
					`OTPC_REG_ADDR: begin
						addr_reg_d = pwdata_i[13:0];
					end
					`OTPC_REG_WDATA: begin
						wdata_reg_d = pwdata_i[7:0];
					end
					default: begin
						cmd_reg_d = cmd_reg_q;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
			prdata_q    <= 32'h0000_0000;
			addr_reg_q  <= `OTPC_ADDR_RST;
			wdata_reg_q <= `OTPC_WDATA_RST;
			cmd_reg_q   <= otpc_pkg::OTPC_CMD_READ;
		end else begin
			pready_q    <= pready_d;
			pslverr_q   <= pslverr_d;
			prdata_q    <= prdata_d;
			addr_reg_q  <= addr_reg_d;
			wdata_reg_q <= wdata_reg_d;
			cmd_reg_q   <= cmd_reg_d;
		end
	end

	// ------------------------------------------------------------------------
	// pin sequencer
	// ------------------------------------------------------------------------
	otpc_timer #(.WIDTH(16)) u_timer (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.load_i    (tm_load),
		.val_i     (tm_val),
		.zero_o    (tm_zero)
	);

	otpc_sync #(.WIDTH(8)) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.async_i   (byte_pins_i),
		.sync_o    (byte_sync)
	);

	always_comb begin
		st_d    = st_q;
		pins_d  = pins_q;
		dat_d   = dat_q;
		oe_d    = oe_q;
		tries_d = tries_q;
		done_d  = done_q;
		fail_d  = fail_q;
		rdata_d = rdata_q;
		tm_load = 1'b0;
		tm_val  = SETUP_LD;
		if (ce_i) begin
			case (st_q)
				otpc_pkg::OTPC_ST_IDLE: begin
					if (start) begin
						tries_d = 4'h0;
						done_d  = 1'b0;
						fail_d  = 1'b0;
						pins_d.chip_on_low = 1'b0;
						pins_d.addr        = addr_reg_q;
						// the order lands in the same edge that starts the run: use it
						if (cmd_reg_d == otpc_pkg::OTPC_CMD_SIG) begin
							pins_d.addr       = {13'h0000, addr_reg_q[0]};
							pins_d.id_volt_hi = 1'b1;
						end
						if (cmd_reg_d == otpc_pkg::OTPC_CMD_PROG) begin
							pins_d.burn_supply_hi = 1'b1;
							pins_d.vcc_prog       = 1'b1;
						end
						tm_load = 1'b1;
						st_d    = otpc_pkg::OTPC_ST_SUPPLY;
					end
				end
				otpc_pkg::OTPC_ST_SUPPLY: begin
					if (tm_zero) begin
						tm_load = 1'b1;
						if (cmd_reg_q == otpc_pkg::OTPC_CMD_PROG) begin
							dat_d = wdata_reg_q;
							oe_d  = 1'b1;
							st_d  = otpc_pkg::OTPC_ST_DATA;
						end else begin
							// plain read at 5 V fetches one byte; there is no final verify pass
							pins_d.out_drv_on_n = 1'b0;
							tm_val = ACC_LD;
							st_d   = otpc_pkg::OTPC_ST_ACCESS;
						end
					end
				end
				otpc_pkg::OTPC_ST_DATA: begin
					if (tm_zero) begin
						pins_d.burn_pulse_n = 1'b0;
						tm_load = 1'b1;
						tm_val  = PULSE_LD;
						st_d    = otpc_pkg::OTPC_ST_PULSE;
					end
				end
				otpc_pkg::OTPC_ST_PULSE: begin
					if (tm_zero) begin
						pins_d.burn_pulse_n = 1'b1;
						tries_d = tries_q + 4'h1;
						tm_load = 1'b1;
						st_d    = otpc_pkg::OTPC_ST_HOLD;
					end
				end
				otpc_pkg::OTPC_ST_HOLD: begin
					if (tm_zero) begin
						oe_d    = 1'b0;
						tm_load = 1'b1;
						tm_val  = DIS_LD;
						st_d    = otpc_pkg::OTPC_ST_TURN;
					end
				end
				otpc_pkg::OTPC_ST_TURN: begin
					if (tm_zero) begin
						pins_d.out_drv_on_n = 1'b0;
						tm_load = 1'b1;
						tm_val  = ACC_LD;
						st_d    = otpc_pkg::OTPC_ST_ACCESS;
					end
				end
				otpc_pkg::OTPC_ST_ACCESS: begin
					if (tm_zero) begin
						rdata_d = byte_sync;
						pins_d.out_drv_on_n = 1'b1;
						tm_load = 1'b1;
						st_d    = otpc_pkg::OTPC_ST_END;
						if (cmd_reg_q != otpc_pkg::OTPC_CMD_PROG) begin
							done_d = 1'b1;
						end else if (byte_sync == wdata_reg_q) begin
							done_d = 1'b1;
						end else if (((~byte_sync & wdata_reg_q) != 8'h00) ||
						             (tries_q >= TRY_MAX)) begin
							// a cleared bit that should be one can never recover
							fail_d = 1'b1;
						end else begin
							tm_val = DIS_LD;
							st_d   = otpc_pkg::OTPC_ST_SUPPLY;
						end
					end
				end
				otpc_pkg::OTPC_ST_END: begin
					pins_d.chip_on_low    = 1'b1;
					pins_d.burn_supply_hi = 1'b0;
					pins_d.vcc_prog       = 1'b0;
					pins_d.id_volt_hi     = 1'b0;
					if (tm_zero) begin
						st_d = otpc_pkg::OTPC_ST_IDLE;
					end
				end
				default: begin
					st_d = otpc_pkg::OTPC_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st_q    <= otpc_pkg::OTPC_ST_IDLE;
			pins_q  <= '{addr: 14'h0000, chip_on_low: 1'b1, out_drv_on_n: 1'b1,
			             burn_pulse_n: 1'b1, burn_supply_hi: 1'b0, vcc_prog: 1'b0,
			             id_volt_hi: 1'b0};
			dat_q   <= 8'h00;
			oe_q    <= 1'b0;
			tries_q <= 4'h0;
			done_q  <= 1'b0;
			fail_q  <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			st_q    <= st_d;
			pins_q  <= pins_d;
			dat_q   <= dat_d;
			oe_q    <= oe_d;
			tries_q <= tries_d;
			done_q  <= done_d;
			fail_q  <= fail_d;
			rdata_q <= rdata_d;
		end
	end

	assign prdata_o         = prdata_q;
	assign pready_o         = pready_q;
	assign pslverr_o        = pslverr_q;
	assign addr_lines_o     = pins_q.addr;
	assign chip_on_low_o    = pins_q.chip_on_low;
	assign out_drv_on_n_o   = pins_q.out_drv_on_n;
	assign burn_pulse_n_o   = pins_q.burn_pulse_n;
	assign burn_supply_hi_o = pins_q.burn_supply_hi;
	assign vcc_prog_o       = pins_q.vcc_prog;
	assign id_volt_hi_o     = pins_q.id_volt_hi;
	assign byte_pins_o      = dat_q;
	assign byte_pins_oe_o   = oe_q;

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	int pulse_len_q;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || pins_q.burn_pulse_n) begin
			pulse_len_q <= 0;
		end else if (ce_i) begin
			pulse_len_q <= pulse_len_q + 1;
		end
	end

	property p_prog_levels;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!pins_q.burn_pulse_n |-> pins_q.burn_supply_hi && pins_q.vcc_prog &&
			!pins_q.chip_on_low && pins_q.out_drv_on_n;
	endproperty
	a_prog_levels: assert property (p_prog_levels)
		else $error("strobe low without program mode levels");

	property p_stable_under_pulse;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(pins_q.burn_pulse_n) |-> oe_q && $stable(pins_q.addr) && $stable(dat_q);
	endproperty
	a_stable_under_pulse: assert property (p_stable_under_pulse)
		else $error("strobe fell while address or data changed");

	property p_pulse_width;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(pins_q.burn_pulse_n) |-> pulse_len_q == PULSE_CYC;
	endproperty
	a_pulse_width: assert property (p_pulse_width)
		else $error("program strobe width wrong");

	property p_verify_follows;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(pins_q.burn_pulse_n) |-> !pins_q.chip_on_low && pins_q.out_drv_on_n;
	endproperty
	a_verify_follows: assert property (p_verify_follows)
		else $error("chip released before verify");

	property p_try_limit;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(pins_q.burn_pulse_n) |-> tries_q < TRY_MAX;
	endproperty
	a_try_limit: assert property (p_try_limit)
		else $error("more program attempts than allowed");

	property p_sig_addr;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		pins_q.id_volt_hi |-> pins_q.addr[13:1] == 13'h0000 && !pins_q.burn_supply_hi;
	endproperty
	a_sig_addr: assert property (p_sig_addr)
		else $error("signature mode with upper address lines high");

	property p_no_contention;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		oe_q |-> pins_q.out_drv_on_n && $past(pins_q.out_drv_on_n, 2);
	endproperty
	a_no_contention: assert property (p_no_contention)
		else $error("host drives data while rom outputs enabled");

	property p_read_at_normal;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!pins_q.out_drv_on_n && cmd_reg_q != otpc_pkg::OTPC_CMD_PROG) |->
			!pins_q.burn_supply_hi && !pins_q.vcc_prog;
	endproperty
	a_read_at_normal: assert property (p_read_at_normal)
		else $error("read issued with programming supplies raised");

	property p_addr_held;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(st_q != otpc_pkg::OTPC_ST_IDLE && $past(st_q) != otpc_pkg::OTPC_ST_IDLE)
			|-> $stable(pins_q.addr);
	endproperty
	a_addr_held: assert property (p_addr_held)
		else $error("address changed during a sequence");

	c_prog_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(done_q) && cmd_reg_q == otpc_pkg::OTPC_CMD_PROG);
	c_prog_fail: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(fail_q));
	c_sig_read: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(done_q) && cmd_reg_q == otpc_pkg::OTPC_CMD_SIG);
	c_retry: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(pins_q.burn_pulse_n) && tries_q == 4'h1);
endmodule : otpc_ctl

/* otpc_consts.svh */
// constants for the one-time-programmable rom controller: offsets, fields, timing
`ifndef OTPC_CONSTS_SVH
`define OTPC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define OTPC_REG_CTRL    12'h000
`define OTPC_REG_ADDR    12'h004
`define OTPC_REG_WDATA   12'h008
`define OTPC_REG_STATUS  12'h00c

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define OTPC_CTRL_START  0
`define OTPC_CTRL_CMD_LO 1
`define OTPC_CTRL_CMD_HI 2
`define OTPC_ST_BUSY     0
`define OTPC_ST_DONE     1
`define OTPC_ST_FAIL     2
`define OTPC_ST_TRY_LO   4
`define OTPC_ST_TRY_HI   7
`define OTPC_ST_RD_LO    8
`define OTPC_ST_RD_HI    15
`define OTPC_ADDR_RST    14'h0000
`define OTPC_WDATA_RST   8'hff

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define OTPC_CLK_MHZ     125
`define OTPC_T_PULSE_US  100
`define OTPC_T_SETUP_US  2
`define OTPC_T_ACC_NS    250
`define OTPC_T_DIS_NS    130
`define OTPC_PULSE_CYC   (`OTPC_T_PULSE_US * `OTPC_CLK_MHZ)
`define OTPC_SETUP_CYC   (`OTPC_T_SETUP_US * `OTPC_CLK_MHZ)
`define OTPC_ACC_CYC     ((`OTPC_T_ACC_NS * `OTPC_CLK_MHZ + 999) / 1000)
`define OTPC_DIS_CYC     ((`OTPC_T_DIS_NS * `OTPC_CLK_MHZ + 999) / 1000)
`define OTPC_SYNC_CYC    2
`define OTPC_MAX_TRIES   10

`endif

/* otpc_pkg.sv */
// types shared by the one-time-programmable rom controller
package otpc_pkg;

	typedef enum logic [1:0] {
		OTPC_CMD_READ = 2'b00,
		OTPC_CMD_PROG = 2'b01,
		OTPC_CMD_SIG  = 2'b10,
		OTPC_CMD_RSVD = 2'b11
	} otpc_cmd_t;

	typedef enum logic [3:0] {
		OTPC_ST_IDLE   = 4'b0000,
		OTPC_ST_SUPPLY = 4'b0001,
		OTPC_ST_DATA   = 4'b0010,
		OTPC_ST_PULSE  = 4'b0011,
		OTPC_ST_HOLD   = 4'b0100,
		OTPC_ST_TURN   = 4'b0101,
		OTPC_ST_ACCESS = 4'b0110,
		OTPC_ST_END    = 4'b0111
	} otpc_state_t;

	// levels driven toward the rom and its supply switches
	typedef struct packed {
		logic [13:0] addr;
		logic        chip_on_low;
		logic        out_drv_on_n;
		logic        burn_pulse_n;
		logic        burn_supply_hi;
		logic        vcc_prog;
		logic        id_volt_hi;
	} otpc_pins_t;

endpackage : otpc_pkg

/* otpc_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module otpc_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	input  wire logic             ce_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = ce_i ? async_i : meta_q;
		sync_d = ce_i ? meta_q : sync_q;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule : otpc_sync

/* otpc_timer.sv */
// loadable down counter; zero_o marks the end of a wait
`timescale 1ns/1ns
module otpc_timer #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	input  wire logic             ce_i,
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] val_i,
	output logic                  zero_o
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (ce_i) begin
			if (load_i) begin
				cnt_d = val_i;
			end else if (cnt_q != '0) begin
				cnt_d = cnt_q - WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign zero_o = (cnt_q == '0);
endmodule : otpc_timer

/* otpc_rom_model.sv */
// behavioural 16k x 8 one-time-programmable rom standing at the controller's pins
`timescale 1ns/1ns
module otpc_rom_model #(
	parameter logic [7:0] CODE_MFG = 8'h5a, // arbitrary value
	parameter logic [7:0] CODE_DEV = 8'h3c, // arbitrary value
	parameter int         PULSE_NS = 160
) (
	input  wire logic [13:0] addr_i,
	input  wire logic        chip_on_low_i,
	input  wire logic        out_drv_on_n_i,
	input  wire logic        burn_pulse_n_i,
	input  wire logic        burn_supply_hi_i,
	input  wire logic        vcc_prog_i,
	input  wire logic        id_volt_hi_i,
	input  wire logic        host_oe_i,
	input  wire logic [7:0]  pins_i,
	input  wire logic [3:0]  slow_i,
	output logic      [7:0]  data_o,
	output logic             err_o
);
	logic [7:0]  mem [16384];
	logic [7:0]  last_q = 8'h00;
	logic [7:0]  d0;
	logic [13:0] a0;
	logic [3:0]  pulses = 4'h0;
	logic        drive;
	logic        late;
	logic        armed = 1'b0;
	time         t0;

	initial begin
		err_o = 1'b0;
		foreach (mem[i]) mem[i] = 8'hff;
	end
	// read, verify and signature drive; standby, disable, program and inhibit float
	assign drive = !chip_on_low_i && !out_drv_on_n_i && burn_pulse_n_i;
	// data settles only after the access time
	assign #240 late = drive;
	// no pull-up: a released bus shows the inverse of the last byte
	assign data_o = (drive && late) ? (id_volt_hi_i ? (addr_i[0] ? CODE_DEV : CODE_MFG)
		: mem[addr_i]) : ~last_q;
	always @(data_o) if (drive && late) last_q = data_o;
	always @(posedge drive) begin
		if (host_oe_i || (id_volt_hi_i && addr_i[13:1] != 13'h0)) err_o = 1'b1;
	end
	always @(negedge burn_supply_hi_i) pulses = 4'h0;
	always @(negedge burn_pulse_n_i) begin
		armed = 1'b1;
		t0 = $time;
		a0 = addr_i;
		d0 = pins_i;
		if (!(burn_supply_hi_i && vcc_prog_i && out_drv_on_n_i && !chip_on_low_i && host_oe_i))
			err_o = 1'b1;
	end
	always @(posedge burn_pulse_n_i) begin
		if (armed) begin
			if ($time - t0 != PULSE_NS || a0 !== addr_i || d0 !== pins_i) err_o = 1'b1;
			if (burn_supply_hi_i && !chip_on_low_i) begin
				if (pulses != 4'hf) pulses = pulses + 4'h1;
				if (pulses >= slow_i) mem[a0] = mem[a0] & d0;
			end
		end
		armed = 1'b0;
	end
endmodule : otpc_rom_model

/* test_otp_uv_rom_mode_and_program_ctl.sv */
// self-checking bench for the otp rom controller against the rom model
`timescale 1ns/1ns
`include "otpc_consts.svh"
module test_otp_uv_rom_mode_and_program_ctl;
	localparam int PULSE_CYC = 20;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [11:0] paddr     = 12'h000;
	logic [31:0] pwdata    = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, serr, err;
	logic [13:0] addr_lines;
	logic        chip_on_low, oe_n, pulse_n, sup_hi, vcc_prog, id_hi, host_oe;
	logic [7:0]  host_d, rom_d, bus;
	logic [3:0]  slow      = 4'h1;
	logic        ce        = 1'b1;
	int          mismatches  = 0;
	int          checks_done = 0;

	assign bus = host_oe ? host_d : rom_d;

	otpc_ctl #(.PULSE_CYC(PULSE_CYC), .SETUP_CYC(4), .MAX_TRIES(10)) dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.addr_lines_o(addr_lines), .chip_on_low_o(chip_on_low), .out_drv_on_n_o(oe_n),
		.burn_pulse_n_o(pulse_n), .burn_supply_hi_o(sup_hi), .vcc_prog_o(vcc_prog),
		.id_volt_hi_o(id_hi), .byte_pins_i(bus), .byte_pins_o(host_d),
		.byte_pins_oe_o(host_oe));

	otpc_rom_model #(.PULSE_NS(PULSE_CYC * 8)) rom (
		.addr_i(addr_lines), .chip_on_low_i(chip_on_low), .out_drv_on_n_i(oe_n),
		.burn_pulse_n_i(pulse_n), .burn_supply_hi_i(sup_hi), .vcc_prog_i(vcc_prog),
		.id_volt_hi_i(id_hi), .host_oe_i(host_oe), .pins_i(bus), .slow_i(slow),
		.data_o(rom_d), .err_o(err));

	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; the answer is awaited, never assumed
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do @(posedge clk_sys_i); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// start a command and poll until busy drops
	task automatic run(input logic [1:0] cmd, input logic [13:0] a, input logic [7:0] d);
		apb(1'b1, `OTPC_REG_ADDR, {18'h0, a});
		apb(1'b1, `OTPC_REG_WDATA, {24'h0, d});
		apb(1'b1, `OTPC_REG_CTRL, {29'h0, cmd, 1'b1});
		do apb(1'b0, `OTPC_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
	endtask : run

	function automatic logic [31:0] st(input logic [7:0] b, input logic [3:0] t,
		input logic f);
		return {16'h0, b, t, 1'b0, f, ~f, 1'b0};
	endfunction : st

	task automatic t_reset;
		chk({25'h0, chip_on_low, oe_n, pulse_n, sup_hi, vcc_prog, id_hi, host_oe}, 32'h70);
		apb(1'b0, `OTPC_REG_ADDR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `OTPC_REG_WDATA, 32'h0);
		chk(rd, 32'hff);
		apb(1'b0, `OTPC_REG_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({rd[30:0], serr}, 32'h1);
	endtask : t_reset

	task automatic t_read_blank;
		run(otpc_pkg::OTPC_CMD_READ, 14'h3fff, 8'h00);
		chk(rd, st(8'hff, 4'h0, 1'b0));
	endtask : t_read_blank

	task automatic prog(input logic [13:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [31:0] exp);
		slow <= s;
		run(otpc_pkg::OTPC_CMD_PROG, a, d);
		chk(rd, exp);
	endtask : prog

	task automatic rd_at(input logic [13:0] a, input logic [7:0] b);
		run(otpc_pkg::OTPC_CMD_READ, a, 8'h00);
		chk(rd & 32'hff07, {16'h0, b, 8'h02});
	endtask : rd_at

	task automatic t_program;
		prog(14'h1234, 8'ha5, 4'h1, st(8'ha5, 4'h1, 1'b0));
		prog(14'h0005, 8'hc3, 4'h3, st(8'hc3, 4'h3, 1'b0));
		rd_at(14'h1234, 8'ha5);
		prog(14'h1234, 8'hff, 4'h1, st(8'ha5, 4'h1, 1'b1));
		rd_at(14'h1234, 8'ha5);
		prog(14'h0007, 8'h00, 4'hf, st(8'hff, 4'ha, 1'b1));
	endtask : t_program

	task automatic t_busy_write;
		slow <= 4'h1;
		apb(1'b1, `OTPC_REG_ADDR, 32'h0100);
		apb(1'b1, `OTPC_REG_CTRL, {29'h0, otpc_pkg::OTPC_CMD_PROG, 1'b1});
		apb(1'b1, `OTPC_REG_ADDR, 32'h0200);
		do apb(1'b0, `OTPC_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
		apb(1'b0, `OTPC_REG_ADDR, 32'h0);
		chk(rd, 32'h0100);
	endtask : t_busy_write

	// clock enable low must freeze a running sequence part way through
	task automatic t_freeze;
		apb(1'b1, `OTPC_REG_ADDR, 32'h1234);
		apb(1'b1, `OTPC_REG_CTRL, {29'h0, otpc_pkg::OTPC_CMD_READ, 1'b1});
		ce <= 1'b0;
		repeat (200) @(posedge clk_sys_i);
		chk({30'h0, chip_on_low, oe_n}, 32'h1);
		ce <= 1'b1;
		do apb(1'b0, `OTPC_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
		chk(rd & 32'hff07, {16'h0, 8'ha5, 8'h02});
	endtask : t_freeze

	task automatic t_signature;
		run(otpc_pkg::OTPC_CMD_SIG, 14'h3ffe, 8'h00);
		chk(rd & 32'hff07, {16'h0, 8'h5a, 8'h02});
		run(otpc_pkg::OTPC_CMD_SIG, 14'h0001, 8'h00);
		chk(rd & 32'hff07, {16'h0, 8'h3c, 8'h02});
	endtask : t_signature

	task automatic report_and_stop;
		if (mismatches == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (50000) @(posedge clk_sys_i);
		mismatches++;
		report_and_stop();
	end

	initial begin
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_read_blank();
		t_program();
		t_busy_write();
		t_signature();
		t_freeze();
		chk({31'h0, err}, 32'h0);
		report_and_stop();
	end
endmodule : test_otp_uv_rom_mode_and_program_ctl
